//--- hw/flsr_regs.sv
// Status and control register bank with link-side command crossing
`timescale 1ns/10ps

module flsr_regs
  import flsr_pkg::*;
#(
  parameter int SR_WRITE_CYC = 8
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        link_clk,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [7:0]  cmd_data,
  output logic             cmd_ready,
  output logic [23:0]      status_view,
  input  wire logic        wp_pin_n,
  input  wire logic [23:0] nv_image,
  input  wire logic        array_done,
  output logic [23:0]      nv_store,
  output logic             op_start,
  output logic [1:0]       op_kind,
  output logic             op_pause,
  output logic             op_resume,
  output logic             busy_flag,
  output logic             qpi_mode,
  output logic             addr4_mode,
  output logic             quad_io_en,
  output logic             hold_func_en,
  output logic             reset_func_en,
  output logic [1:0]       drive_strength,
  output logic             block_protect_active,
  output logic [4:0]       protect_field,
  output logic             protect_complement,
  output logic             protection_scheme_select,
  output logic [2:0]       security_lock
);

  if (SR_WRITE_CYC < 1 || SR_WRITE_CYC > 255) begin : g_chk
    $error("SR_WRITE_CYC must lie in 1..255");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: reset sync, command hold, status capture

  logic        lrst_s1;
  logic        lrst_s2;
  logic        req_tog;
  logic [7:0]  cmd_code_q;
  logic [7:0]  cmd_data_q;
  logic        ack_s1;
  logic        ack_s2;
  logic        snap_s1;
  logic        snap_s2;
  logic        snap_s3;
  logic [23:0] snap;
  logic        snap_tog;
  logic        req_s3;

  wire link_rst = !lrst_s2;
  wire send     = cmd_valid && cmd_ready;
  wire next_req = req_tog ^ send;

  always_ff @(posedge link_clk) begin
    lrst_s1 <= nrst;
    lrst_s2 <= lrst_s1;
  end

  always_ff @(posedge link_clk) begin
    ack_s1 <= req_s3;
    ack_s2 <= ack_s1;
    snap_s1 <= snap_tog;
    snap_s2 <= snap_s1;
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      req_tog     <= 1'b0;
      cmd_ready   <= 1'b0;
      cmd_code_q  <= 8'h00;
      cmd_data_q  <= 8'h00;
      snap_s3     <= 1'b0;
      status_view <= STATUS_RST;
    end else begin
      req_tog   <= next_req;
      cmd_ready <= !send && (next_req == ack_s2);
      if (send) begin
        cmd_code_q <= cmd_code;
        cmd_data_q <= cmd_data;
      end
      snap_s3 <= snap_s2;
      if (snap_s2 != snap_s3) begin
        status_view <= snap;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Core domain: synchronisers and command detect

  logic        req_s1;
  logic        req_s2;
  logic        sack_s1;
  logic        sack_s2;
  logic        wp_s1;
  logic        wp_s2;
  logic [23:0] sr;
  logic        qpi;
  logic [7:0]  cnt;
  flsr_state_e st;

  always_ff @(posedge core_clk) begin
    req_s1  <= req_tog;
    req_s2  <= req_s1;
    sack_s1 <= snap_s3;
    sack_s2 <= sack_s1;
    wp_s1   <= wp_pin_n;
    wp_s2   <= wp_s1;
  end

  // Command words are stable while the request toggle is unanswered
  wire       consume = (req_s2 != req_s3) && (st != ST_INIT);
  wire [7:0] op      = cmd_code_q;
  wire       is_wrsr = (op == OP_WRSR1) || (op == OP_WRSR2) || (op == OP_WRSR3);
  wire       is_arr  = (op == OP_PP) || (op == OP_SE) || (op == OP_BE) || (op == OP_CE);
  wire       idle    = (st == ST_IDLE) || (st == ST_SUSP);
  wire       write_enable_latch     = sr[BIT_WEL];
  wire       qe      = sr[BIT_QE];
  wire [1:0] lock    = {sr[BIT_LOCK_HI], sr[BIT_LOCK_LO]};

  // Write-protect pin acts only while it is not a data line
  wire wp_high = wp_s2 || qe;

  wire sr_write_ok = (lock == 2'b00)
                  || ((lock == 2'b01) && wp_high);

  wire [23:0] lane = (op == OP_WRSR1) ? LANE_LOW
                   : (op == OP_WRSR2) ? LANE_MID : LANE_HIGH;
  wire [23:0] wmask  = lane & WR_MASK;
  wire [23:0] qe_bit = 24'h000001 << BIT_QE;
  wire [23:0] merged = (sr & ~wmask) | ({3{cmd_data_q}} & wmask)
                     | (sr & OTP_MASK)
                     | (qpi ? qe_bit : 24'h000000);

  wire [2:0] bp_lo  = sr[BIT_BP_LO+:3];
  wire       ce_ok  = sr[BIT_WPS]
                   || ((bp_lo == 3'b000) && !sr[BIT_CMP])
                   || ((bp_lo == 3'b111) && sr[BIT_CMP]);

  wire [1:0] kind = (op == OP_PP) ? KIND_PP : (op == OP_SE) ? KIND_SE
                  : (op == OP_BE) ? KIND_BE : KIND_CE;

  // Loaded image: power-cycle lock clears, address mode from power-up bit
  wire [23:0] nv_in   = nv_image & NV_MASK;
  wire        lock_pc = nv_in[BIT_LOCK_HI] && !nv_in[BIT_LOCK_LO];

  //////////////////////////////////////////////////////////////////////////////
  // Core next-state logic

  logic [23:0] next_sr;
  flsr_state_e next_st;
  logic        next_qpi;
  logic [7:0]  next_cnt;
  logic        next_start;
  logic        next_pause;
  logic        next_resume;

  always_comb begin
    next_sr     = sr;
    next_st     = st;
    next_qpi    = qpi;
    next_cnt    = cnt;
    next_start  = 1'b0;
    next_pause  = 1'b0;
    next_resume = 1'b0;
    unique case (st)
      ST_INIT: begin
        next_sr = nv_in;
        if (lock_pc) begin
          next_sr[BIT_LOCK_HI] = 1'b0;
        end
        next_sr[BIT_ADS] = nv_in[BIT_ADP];
        next_st          = ST_IDLE;
      end
      ST_SRW: begin
        next_cnt = cnt - 8'd1;
        if (cnt == 8'd1) begin
          next_st = ST_IDLE;
        end
      end
      ST_ARRAY: begin
        if (array_done) begin
          next_st = ST_IDLE;
        end else if (consume && op == OP_SUSP) begin
          next_pause = 1'b1;
          next_st    = ST_SUSP;
          if (op_kind == KIND_PP) begin
            next_sr[BIT_PSUS] = 1'b1;
          end else begin
            next_sr[BIT_ESUS] = 1'b1;
          end
        end
      end
      default: begin
      end
    endcase
    if (consume && idle) begin
      if (op == OP_WREN) begin
        next_sr[BIT_WEL] = 1'b1;
      end
      if (op == OP_WRDI) begin
        next_sr[BIT_WEL] = 1'b0;
      end
      if (is_wrsr && write_enable_latch) begin
        next_sr[BIT_WEL] = 1'b0;
        if (sr_write_ok && st == ST_IDLE) begin
          next_sr[23:2] = merged[23:2];
          next_sr[BIT_ADS]  = sr[BIT_ADS];
          next_sr[BIT_PSUS] = sr[BIT_PSUS];
          next_sr[BIT_ESUS] = sr[BIT_ESUS];
          next_st  = ST_SRW;
          next_cnt = 8'(SR_WRITE_CYC);
        end
      end
      if (is_arr && write_enable_latch && st == ST_IDLE) begin
        next_sr[BIT_WEL] = 1'b0;
        if (op != OP_CE || ce_ok) begin
          next_start = 1'b1;
          next_st    = ST_ARRAY;
        end
      end
      if (op == OP_RESUME && st == ST_SUSP) begin
        next_sr[BIT_ESUS] = 1'b0;
        next_sr[BIT_PSUS] = 1'b0;
        next_resume = 1'b1;
        next_st     = ST_ARRAY;
      end
      if (op == OP_QPI_EN && qe) begin
        next_qpi = 1'b1;
      end
      if (op == OP_QPI_EX) begin
        next_qpi = 1'b0;
      end
      if (op == OP_ADDR4_EN) begin
        next_sr[BIT_ADS] = 1'b1;
      end
      if (op == OP_ADDR4_EX) begin
        next_sr[BIT_ADS] = 1'b0;
      end
    end
    next_sr[BIT_BUSY] = (next_st == ST_SRW) || (next_st == ST_ARRAY);
    next_sr[20:19]    = 2'b00;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Core registers and outputs

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st      <= ST_INIT;
      sr      <= STATUS_RST;
      qpi     <= 1'b0;
      cnt     <= 8'h00;
      req_s3  <= 1'b0;
      op_kind <= KIND_PP;
    end else begin
      st     <= next_st;
      sr     <= next_sr;
      qpi    <= next_qpi;
      cnt    <= next_cnt;
      req_s3 <= (st == ST_INIT) ? req_s3 : req_s2;
      if (next_start) begin
        op_kind <= kind;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      op_start                 <= 1'b0;
      op_pause                 <= 1'b0;
      op_resume                <= 1'b0;
      nv_store                 <= STATUS_RST;
      busy_flag                <= 1'b0;
      qpi_mode                 <= 1'b0;
      addr4_mode               <= 1'b0;
      quad_io_en               <= 1'b0;
      hold_func_en             <= 1'b0;
      reset_func_en            <= 1'b0;
      drive_strength           <= 2'b00;
      block_protect_active     <= 1'b0;
      protect_field            <= 5'h00;
      protect_complement       <= 1'b0;
      protection_scheme_select <= 1'b0;
      security_lock            <= 3'h0;
    end else begin
      op_start                 <= next_start;
      op_pause                 <= next_pause;
      op_resume                <= next_resume;
      nv_store                 <= next_sr & NV_MASK;
      busy_flag                <= next_sr[BIT_BUSY];
      qpi_mode                 <= next_qpi;
      addr4_mode               <= next_sr[BIT_ADS];
      quad_io_en               <= next_sr[BIT_QE];
      hold_func_en             <= !next_sr[BIT_QE] && !next_sr[BIT_HOLDRST];
      reset_func_en            <= !next_sr[BIT_QE] && next_sr[BIT_HOLDRST];
      drive_strength           <= next_sr[BIT_DRV_LO+:2];
      block_protect_active     <= !next_sr[BIT_WPS];
      protect_field            <= next_sr[BIT_BP_LO+:5];
      protect_complement       <= next_sr[BIT_CMP];
      protection_scheme_select <= next_sr[BIT_WPS];
      security_lock            <= next_sr[BIT_LB_LO+:3];
    end
  end

  // Status snapshot towards the link, one word per handshake
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      snap     <= STATUS_RST;
      snap_tog <= 1'b0;
    end else if (snap_tog == sack_s2 && snap != sr) begin
      snap     <= sr;
      snap_tog <= !snap_tog;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  wire [23:0] otp_now = sr & OTP_MASK;

  a_busy_state: assert property (sr[BIT_BUSY] == (st == ST_SRW || st == ST_ARRAY))
    else $error("busy flag disagrees with state");
  a_wel_gate: assert property (consume && is_arr && !write_enable_latch |=> !op_start)
    else $error("array op started without write enable");
  a_bp_frozen: assert property (consume && is_wrsr && lock == 2'b01 && !wp_high
    |=> $stable(sr[BIT_BP_LO+:5]))
    else $error("protect field changed under hardware lock");
  a_ce_gate: assert property (op_start && op_kind == KIND_CE |-> $past(ce_ok))
    else $error("chip erase started with protect field set");
  a_soft_write: assert property (consume && op == OP_WRSR1 && write_enable_latch && st == ST_IDLE
    && lock == 2'b00 |=> sr[BIT_BP_LO+:5] == $past(cmd_data_q[6:2]) && st == ST_SRW)
    else $error("unlocked status write not applied");
  a_lock_hold: assert property (lock == 2'b11 && st != ST_INIT |=> lock == 2'b11)
    else $error("permanent lock released");
  a_qpi_qe: assert property (qpi |-> qe)
    else $error("quad enable low in QPI mode");
  a_otp_keep: assert property (st != ST_INIT |=> ($past(otp_now) & ~otp_now) == 24'h0)
    else $error("one-time bit cleared");
  a_susp_flag: assert property (st == ST_SUSP |-> sr[BIT_ESUS] || sr[BIT_PSUS])
    else $error("suspended without suspend flag");
  a_init_mode: assert property (st == ST_INIT |=> sr[BIT_ADS] == sr[BIT_ADP])
    else $error("start address mode not from power-up bit");
  a_pin_func: assert property (st != ST_INIT
    |-> hold_func_en == (!sr[BIT_QE] && !sr[BIT_HOLDRST]))
    else $error("hold function wrong");

  c_erase_susp: cover property (st == ST_ARRAY ##1 st == ST_SUSP ##[1:50] st == ST_ARRAY);
  c_sr_write: cover property (st == ST_IDLE ##1 st == ST_SRW);
  c_qpi: cover property (!qpi ##1 qpi);
  c_ce: cover property (op_start && op_kind == KIND_CE);

endmodule : flsr_regs

//--- hw/flsr_pkg.sv
// Constants for the flash status and control register bank
package flsr_pkg;

  // Instruction codes seen by the register bank
  localparam logic [7:0] OP_WREN     = 8'h06;
  localparam logic [7:0] OP_WRDI     = 8'h04;
  localparam logic [7:0] OP_WRSR1    = 8'h01;
  localparam logic [7:0] OP_WRSR2    = 8'h31;
  localparam logic [7:0] OP_WRSR3    = 8'h11;
  localparam logic [7:0] OP_PP       = 8'h02;
  localparam logic [7:0] OP_SE       = 8'h20;
  localparam logic [7:0] OP_BE       = 8'hd8;
  localparam logic [7:0] OP_CE       = 8'hc7;
  localparam logic [7:0] OP_SUSP     = 8'h75;
  localparam logic [7:0] OP_RESUME   = 8'h7a;
  localparam logic [7:0] OP_QPI_EN   = 8'h38;
  localparam logic [7:0] OP_QPI_EX   = 8'hff;
  localparam logic [7:0] OP_ADDR4_EN = 8'hb7;
  localparam logic [7:0] OP_ADDR4_EX = 8'he9;

  // Bit positions in the 24-bit status image
  localparam int BIT_BUSY    = 0;
  localparam int BIT_WEL     = 1;
  localparam int BIT_BP_LO   = 2;
  localparam int BIT_LOCK_LO = 7;
  localparam int BIT_LOCK_HI = 8;
  localparam int BIT_QE      = 9;
  localparam int BIT_PSUS    = 10;
  localparam int BIT_LB_LO   = 11;
  localparam int BIT_CMP     = 14;
  localparam int BIT_ESUS    = 15;
  localparam int BIT_ADS     = 16;
  localparam int BIT_ADP     = 17;
  localparam int BIT_WPS     = 18;
  localparam int BIT_DRV_LO  = 21;
  localparam int BIT_HOLDRST = 23;

  // Byte lanes and masks of the status image
  localparam logic [23:0] LANE_LOW   = 24'h0000ff;
  localparam logic [23:0] LANE_MID   = 24'h00ff00;
  localparam logic [23:0] LANE_HIGH  = 24'hff0000;
  localparam logic [23:0] WR_MASK    = 24'he67bfc;
  localparam logic [23:0] NV_MASK    = 24'he67bfc;
  localparam logic [23:0] OTP_MASK   = 24'h043800;
  localparam logic [23:0] STATUS_RST = 24'h000000;

  // Array operation kinds
  localparam logic [1:0] KIND_PP = 2'd0;
  localparam logic [1:0] KIND_SE = 2'd1;
  localparam logic [1:0] KIND_BE = 2'd2;
  localparam logic [1:0] KIND_CE = 2'd3;

  typedef enum logic [2:0] {ST_INIT, ST_IDLE, ST_SRW, ST_ARRAY, ST_SUSP} flsr_state_e;

endpackage : flsr_pkg

//--- sim/flsr_host_model.sv
// Host controller model offering decoded commands over the link
`timescale 1ns/10ps
module flsr_host_model (
  output logic             link_clk,
  output logic             cmd_valid,
  output logic [7:0]       cmd_code,
  output logic [7:0]       cmd_data,
  input  wire logic        cmd_ready,
  input  wire logic [23:0] status_view
);
  int timeouts = 0;
  initial begin
    link_clk  = 1'b1;
    cmd_valid = 1'b0;
    cmd_code  = 8'h00;
    cmd_data  = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  // One link period; clock idles high and stands still between calls
  task automatic tick();
    #60.5 link_clk = 1'b0;
    #62.5 link_clk = 1'b1;
    #2;
  endtask : tick
  task automatic run(input int n);
    repeat (n) tick();
  endtask : run
  task automatic wait_ready();
    int k;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 40) begin
      tick();
      k++;
    end
    if (cmd_ready !== 1'b1) timeouts++;
  endtask : wait_ready
  // Held until the taking edge; released lines flip so no stale value shows
  task automatic issue(input logic [7:0] code, input logic [7:0] data);
    wait_ready();
    cmd_valid = 1'b1;
    cmd_code  = code;
    cmd_data  = data;
    tick();
    cmd_valid = 1'b0;
    cmd_code  = ~code;
    cmd_data  = ~data;
    tick();
    wait_ready();
  endtask : issue
  task automatic read_status(output logic [23:0] s);
    run(16);
    s = status_view;
  endtask : read_status
endmodule : flsr_host_model

//--- sim/flsr_regs_tb_top.sv
// Self-checking bench for the status register bank
`timescale 1ns/10ps
module flsr_regs_tb_top;
  import flsr_pkg::*;
  logic        core_clk, nrst, wp_pin_n, array_done;
  logic        link_clk, cmd_valid, cmd_ready;
  logic [7:0]  cmd_code, cmd_data;
  logic [23:0] nv_image, status_view;
  logic        op_start, op_pause, op_resume, busy_flag, qpi_mode, addr4_mode;
  logic        quad_io_en, hold_func_en, reset_func_en, scheme_sel;
  logic [1:0]  op_kind, drive_strength, last_kind;
  logic [4:0]  protect_field;
  logic [2:0]  security_lock;
  logic [23:0] nv_store;
  logic        bp_active, cmp_out;
  int          fail_count = 0;
  int          n_compared = 0;
  int          n_start = 0;
  int          n_pause = 0;
  int          n_resume = 0;
  logic [7:0]  arr_ops [3] = '{OP_PP, OP_SE, OP_BE};

  flsr_regs #(.SR_WRITE_CYC(2)) dut (
    .core_clk(core_clk), .nrst(nrst), .link_clk(link_clk), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .status_view(status_view), .wp_pin_n(wp_pin_n), .nv_image(nv_image),
    .array_done(array_done), .nv_store(nv_store), .op_start(op_start), .op_kind(op_kind),
    .op_pause(op_pause), .op_resume(op_resume), .busy_flag(busy_flag),
    .qpi_mode(qpi_mode), .addr4_mode(addr4_mode), .quad_io_en(quad_io_en),
    .hold_func_en(hold_func_en), .reset_func_en(reset_func_en),
    .drive_strength(drive_strength), .block_protect_active(bp_active),
    .protect_field(protect_field), .protect_complement(cmp_out),
    .protection_scheme_select(scheme_sel), .security_lock(security_lock)
  );

  flsr_host_model host (
    .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .status_view(status_view)
  );

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Array engine side: count launches and pauses
  always @(posedge core_clk) begin
    if (op_start === 1'b1) begin
      n_start <= n_start + 1;
      last_kind <= op_kind;
    end
    if (op_pause === 1'b1) n_pause <= n_pause + 1;
    if (op_resume === 1'b1) n_resume <= n_resume + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("Compared %0d, mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic cmd(input logic [7:0] code, input logic [7:0] data);
    host.issue(code, data);
    if (host.timeouts != 0) begin
      fail_count++;
      end_of_test();
    end
  endtask : cmd
  task automatic wcmd(input logic [7:0] code, input logic [7:0] data);
    cmd(OP_WREN, 8'h00);
    cmd(code, data);
  endtask : wcmd
  task automatic st(input logic [23:0] exp);
    logic [23:0] s;
    host.read_status(s);
    check("status_view", exp, s);
  endtask : st
  task automatic pulse_done();
    @(posedge core_clk);
    #2 array_done = 1'b1;
    @(posedge core_clk);
    #2 array_done = 1'b0;
  endtask : pulse_done
  task automatic do_reset(input logic [23:0] img);
    @(posedge core_clk);
    #2 nrst = 1'b0;
    nv_image = img;
    host.run(4);
    @(posedge core_clk);
    #2 nrst = 1'b1;
  endtask : do_reset
  task automatic set_wp(input logic v);
    @(posedge core_clk);
    #2 wp_pin_n = v;
  endtask : set_wp
  ////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    wp_pin_n = 1'b1;
    array_done = 1'b0;
    nv_image = 24'h020100;
    do_reset(24'h020100);
    st(24'h030000);
    check("addr4_mode", 1, addr4_mode);
    check("nv_store", 24'h020000, nv_store);
    do_reset(24'h000000);
    st(24'h000000);
    check("hold_func_en", 1, hold_func_en);
    check("block_protect_active", 1, bp_active);
    cmd(OP_ADDR4_EN, 8'h00);
    check("addr4_mode", 1, addr4_mode);
    cmd(OP_ADDR4_EX, 8'h00);
    check("addr4_mode", 0, addr4_mode);
    cmd(OP_WRSR1, 8'h1c);
    cmd(OP_SE, 8'h00);
    check("starts", 0, n_start);
    st(24'h000000);
    cmd(OP_WREN, 8'h00);
    st(24'h000002);
    cmd(OP_WRDI, 8'h00);
    st(24'h000000);
    cmd(OP_WREN, 8'h00);
    cmd(OP_WRSR1, 8'h1c);
    st(24'h00001c);
    check("protect_field", 5'h07, protect_field);
    // Chip erase: refused with field 111 and complement 0, taken with 1
    wcmd(OP_CE, 8'h00);
    check("ce starts", 0, n_start);
    st(24'h00001c);
    wcmd(OP_WRSR2, 8'h40);
    wcmd(OP_CE, 8'h00);
    check("ce starts", 1, n_start);
    check("op_kind", KIND_CE, last_kind);
    st(24'h00401d);
    check("busy_flag", 1, busy_flag);
    check("protect_complement", 1, cmp_out);
    pulse_done();
    wcmd(OP_WRSR2, 8'h00);
    wcmd(OP_WRSR1, 8'h00);
    st(24'h000000);
    for (int i = 0; i < 3; i++) begin
      wcmd(arr_ops[i], 8'h00);
      check("op_kind", i, last_kind);
      st(24'h000001);
      cmd(OP_SUSP, 8'h00);
      st(i == 0 ? 24'h000400 : 24'h008000);
      cmd(OP_RESUME, 8'h00);
      st(24'h000001);
      pulse_done();
      st(24'h000000);
    end
    check("pauses", 3, n_pause);
    check("resumes", 3, n_resume);
    // Hardware status protection follows the pin
    wcmd(OP_WRSR1, 8'h80);
    set_wp(1'b0);
    wcmd(OP_WRSR1, 8'h9c);
    st(24'h000080);
    set_wp(1'b1);
    wcmd(OP_WRSR1, 8'h84);
    st(24'h000084);
    wcmd(OP_WRSR1, 8'h00);
    cmd(OP_QPI_EN, 8'h00);
    check("qpi_mode", 0, qpi_mode);
    wcmd(OP_WRSR2, 8'h02);
    st(24'h000200);
    check("quad_io_en", 1, quad_io_en);
    check("hold_func_en", 0, hold_func_en);
    cmd(OP_QPI_EN, 8'h00);
    check("qpi_mode", 1, qpi_mode);
    wcmd(OP_WRSR2, 8'h00);
    st(24'h000200);
    wcmd(OP_WRSR2, 8'h0a);
    wcmd(OP_WRSR2, 8'h02);
    st(24'h000a00);
    check("security_lock", 3'b001, security_lock);
    for (int d = 0; d < 4; d++) begin
      wcmd(OP_WRSR3, {1'b0, 2'(d), 5'h07});
      check("drive_strength", d, drive_strength);
    end
    st(24'h660a00);
    check("addr4_mode", 0, addr4_mode);
    check("block_protect_active", 0, bp_active);
    wcmd(OP_WRSR3, 8'h80);
    st(24'h840a00);
    check("scheme_sel", 1, scheme_sel);
    check("reset_func_en", 0, reset_func_en);
    // Lock 11 freezes all status register writes; QPI exit still works
    wcmd(OP_WRSR1, 8'h80);
    wcmd(OP_WRSR2, 8'h0b);
    wcmd(OP_WRSR1, 8'h00);
    wcmd(OP_WRSR2, 8'h02);
    st(24'h840b80);
    check("nv_store", 24'h840b80, nv_store);
    cmd(OP_QPI_EX, 8'h00);
    check("qpi_mode", 0, qpi_mode);
    end_of_test();
  end
endmodule : flsr_regs_tb_top
